// File: design/sar_seq_consts.vh
// constants for the successive-approximation conversion sequencer
`ifndef SAR_SEQ_CONSTS_VH
`define SAR_SEQ_CONSTS_VH
`define SAR_BITS 16
`define SAR_MSB 15
`define SAR_MIDSCALE_SB 16'h8000
`define SAR_MAX_SB 16'hFFFF
`define SAR_MAX_TC 16'h7FFF
`define SAR_MIN_SB 16'h0000
`define SAR_MIN_TC 16'h8000
`define SAR_CLK_HZ 40000000
`define SAR_RATE_SPS 1330000
`define SAR_CYCLE_CLKS (`SAR_CLK_HZ / `SAR_RATE_SPS)
`define SAR_ACQ_CLKS 8'h08
`define SAR_GND_OPEN_CLKS 1
`define SAR_FIFO_DEPTH 8
`define SAR_FIFO_AW 3
`endif

// File: design/sar_code_fifo.v
// small synchronous fifo holding finished conversion codes
`timescale 1ns/10ps
`default_nettype none
module sar_code_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire mclk,
  input wire reset,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;
  assign in_ready = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_ff];
  always @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end
  always @(posedge mclk) begin
    if (reset) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: design/sar_conversion_sequencer.v
// control sequencer of a 16-bit differential charge-redistribution converter
`timescale 1ns/10ps
`default_nettype none
`include "sar_seq_consts.vh"
// Function
// - acquisition: comparator nodes to analog ground, all element switches to inputs
// - convert only after acquisition ends and conversion_start_n is low
// - open ground switches first, then move arrays from inputs to reference ground
// - sixteen binary-weighted trials, msb first, keep or clear per comparator
// - after last decision form the code, then drop busy
// - each presented code is the oldest unread one in the 8-entry code fifo
// - output_coding_select picks straight binary or two's complement (top bit inverted)
// - over-range saturates to maximum code of the chosen coding
// - under-range saturates to minimum code of the chosen coding, unless over-range is also set, which gives the maximum code
// - after each conversion the analogue circuits go to low power
// - full cycle fits 1.33 million conversions per second
// - a falling edge on conversion_start_n starts a conversion only if acquisition has ended and the fifo has room, else it is dropped
// - a running conversion ignores further starts and power_down_input
module sar_conversion_sequencer (
  input wire mclk,
  input wire reset,
  input wire conversion_start_n,
  input wire output_coding_select,
  input wire power_down_input,
  input wire comparator_high,
  input wire over_range,
  input wire under_range,
  output reg busy,
  output reg positive_array_ground_switch,
  output reg negative_array_ground_switch,
  output reg arrays_to_inputs,
  output reg arrays_to_reference_ground,
  output reg [15:0] element_to_reference,
  output reg analog_powered,
  output wire code_valid,
  input wire code_ready,
  output wire [15:0] code_data,
  output wire start_overrun
);
  localparam [2:0] ST_ACQ = 3'h0;
  localparam [2:0] ST_OPEN_GND = 3'h1;
  localparam [2:0] ST_HOLD = 3'h2;
  localparam [2:0] ST_TRIAL = 3'h3;
  localparam [2:0] ST_CODE = 3'h5;
  localparam [2:0] ST_DONE = 3'h6;
  localparam [7:0] acq_clks = `SAR_ACQ_CLKS;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg start_d_ff;
  reg [7:0] acq_cnt_ff;
  reg [7:0] nxt_acq_cnt;
  reg [3:0] bit_ff;
  reg [3:0] nxt_bit;
  reg [15:0] sar_ff;
  reg [15:0] nxt_sar;
  reg ovr_ff;
  reg nxt_ovr;
  reg udr_ff;
  reg nxt_udr;
  reg [15:0] code_ff;
  reg [15:0] nxt_code;
  reg push_ff;
  reg nxt_push;
  reg overrun_ff;
  wire start_fall;
  wire acq_done;
  wire fifo_ready;
  wire [15:0] one_hot;
  assign start_fall = start_d_ff && !conversion_start_n;
  assign acq_done = (acq_cnt_ff == acq_clks);
  assign start_overrun = overrun_ff;
  assign one_hot = 16'h0001 << bit_ff;
  always @(posedge mclk) begin
    if (reset) begin
      start_d_ff <= 1'b1;
    end else begin
      start_d_ff <= conversion_start_n;
    end
  end
  always @* begin
    nxt_state = state_ff;
    nxt_acq_cnt = acq_cnt_ff;
    nxt_bit = bit_ff;
    nxt_sar = sar_ff;
    nxt_ovr = ovr_ff;
    nxt_udr = udr_ff;
    nxt_code = code_ff;
    nxt_push = 1'b0;
    case (state_ff)
      ST_ACQ: begin
        if (!acq_done) begin
          nxt_acq_cnt = acq_cnt_ff + 8'h01;
        end
        if (start_fall && acq_done && fifo_ready) begin
          nxt_state = ST_OPEN_GND;
        end
      end
      ST_OPEN_GND: begin
        nxt_state = ST_HOLD;
      end
      ST_HOLD: begin
        nxt_ovr = over_range;
        nxt_udr = under_range;
        nxt_bit = 4'hF;
        nxt_sar = 16'h0000;
        nxt_state = ST_TRIAL;
      end
      ST_TRIAL: begin
        if (comparator_high) begin
          nxt_sar = sar_ff | one_hot;
        end
        if (bit_ff == 4'h0) begin
          nxt_state = ST_CODE;
        end else begin
          nxt_bit = bit_ff - 4'h1;
        end
      end
      ST_CODE: begin
        if (ovr_ff) begin
          nxt_code = output_coding_select ? `SAR_MAX_TC : `SAR_MAX_SB;
        end else if (udr_ff) begin
          nxt_code = output_coding_select ? `SAR_MIN_TC : `SAR_MIN_SB;
        end else begin
          nxt_code = {sar_ff[`SAR_MSB] ^ output_coding_select, sar_ff[14:0]};
        end
        nxt_push = 1'b1;
        nxt_state = ST_DONE;
      end
      ST_DONE: begin
        nxt_acq_cnt = 8'h00;
        nxt_state = ST_ACQ;
      end
      default: begin
        nxt_state = ST_ACQ;
      end
    endcase
  end
  always @(posedge mclk) begin
    if (reset) begin
      state_ff <= ST_ACQ;
      acq_cnt_ff <= 8'h00;
      bit_ff <= 4'h0;
      sar_ff <= 16'h0000;
      ovr_ff <= 1'b0;
      udr_ff <= 1'b0;
      code_ff <= 16'h0000;
      push_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      acq_cnt_ff <= nxt_acq_cnt;
      bit_ff <= nxt_bit;
      sar_ff <= nxt_sar;
      ovr_ff <= nxt_ovr;
      udr_ff <= nxt_udr;
      code_ff <= nxt_code;
      push_ff <= nxt_push;
      overrun_ff <= start_fall && (state_ff != ST_ACQ);
    end
  end
  always @* begin
    busy = (state_ff != ST_ACQ);
    positive_array_ground_switch = (state_ff == ST_ACQ);
    negative_array_ground_switch = (state_ff == ST_ACQ);
    arrays_to_inputs = (state_ff == ST_ACQ) || (state_ff == ST_OPEN_GND);
    arrays_to_reference_ground = !arrays_to_inputs;
    element_to_reference = 16'h0000;
    if (state_ff == ST_TRIAL) begin
      element_to_reference = sar_ff | one_hot;
    end
    analog_powered = (state_ff != ST_ACQ) && (state_ff != ST_DONE);
    if (state_ff == ST_ACQ && power_down_input) begin
      analog_powered = 1'b0;
    end
  end
  // one trial per clock: 20 busy clocks, 8 acquisition clocks and the start edge fit 30 clocks
  sar_code_fifo #(
    .WIDTH(`SAR_BITS),
    .DEPTH(`SAR_FIFO_DEPTH),
    .AW(`SAR_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_valid(push_ff),
    .in_ready(fifo_ready),
    .in_data(code_ff),
    .out_valid(code_valid),
    .out_ready(code_ready),
    .out_data(code_data)
  );
endmodule
`default_nettype wire

// File: testbench/sar_seq_checker.sv
// port assertions for the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module sar_seq_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic conversion_start_n,
  input wire logic busy,
  input wire logic positive_array_ground_switch,
  input wire logic negative_array_ground_switch,
  input wire logic arrays_to_inputs,
  input wire logic arrays_to_reference_ground,
  input wire logic [15:0] element_to_reference,
  input wire logic analog_powered,
  input wire logic start_overrun
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_start_edge: assert property ($rose(busy) |->
    $past(conversion_start_n, 2) && !$past(conversion_start_n)) else $error("busy without edge");
  a_busy_span: assert property ($rose(busy) |->
    busy[*8] ##1 busy[*8] ##1 busy[*4] ##1 !busy) else $error("busy length wrong");
  a_acq_guard: assert property ($fell(busy) |-> !busy[*8])
    else $error("start taken during acquisition");
  a_ground_open: assert property (busy |->
    !positive_array_ground_switch && !negative_array_ground_switch) else $error("ground closed");
  a_idle_track: assert property (!busy |-> positive_array_ground_switch &&
    negative_array_ground_switch && arrays_to_inputs) else $error("idle not tracking");
  a_open_first: assert property ($rose(busy) |-> arrays_to_inputs ##1 !arrays_to_inputs)
    else $error("arrays moved too early");
  a_ref_inverse: assert property (arrays_to_reference_ground != arrays_to_inputs)
    else $error("arrays on both sides");
  a_msb_first: assert property ($rose(busy) |-> ##[1:3] element_to_reference == 16'h8000)
    else $error("first trial not msb");
  a_idle_power: assert property (!busy |->
    !analog_powered && element_to_reference == 16'h0000) else $error("powered while idle");
  a_overrun_flag: assert property (busy && $past(busy) &&
    $fell(conversion_start_n) |=> start_overrun) else $error("overrun not flagged");
endmodule
bind sar_conversion_sequencer sar_seq_checker i_sar_seq_checker (.mclk, .reset,
  .conversion_start_n, .busy, .positive_array_ground_switch, .negative_array_ground_switch,
  .arrays_to_inputs, .arrays_to_reference_ground, .element_to_reference, .analog_powered,
  .start_overrun);
`default_nettype wire

// File: testbench/sar_host_model.sv
// host model: start pulses and code reads with stalls
`timescale 1ns/10ps
`default_nettype none
module sar_host_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic stall,
  output var logic conversion_start_n,
  output var logic code_ready
);
  initial conversion_start_n = 1'b1;
  initial code_ready = 1'b0;
  always @(posedge mclk) begin
    conversion_start_n <= !go;
    code_ready <= !stall && ($urandom % 3 != 0);
  end
endmodule
`default_nettype wire

// File: testbench/sar_conversion_sequencer_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module sar_conversion_sequencer_tb;
  logic mclk = 0, reset = 1, go = 0, stall = 0, sel = 0, pd = 0, ovr = 0, und = 0;
  logic [15:0] target = 0;
  wire logic busy, pgs, ngs, ati, atr, pwr, cv, cr, start_n, ovf;
  wire logic [15:0] elem, data;
  logic [15:0] q[$];
  int errors = 0, n_checks = 0, i;
  always #12.5 mclk = ~mclk;
  sar_host_model i_sar_host_model (.mclk(mclk), .go(go), .stall(stall),
    .conversion_start_n(start_n), .code_ready(cr));
  sar_conversion_sequencer i_sar_conversion_sequencer (.mclk(mclk), .reset(reset),
    .conversion_start_n(start_n), .output_coding_select(sel), .power_down_input(pd),
    .comparator_high(elem <= target), .over_range(ovr), .under_range(und), .busy(busy),
    .positive_array_ground_switch(pgs), .negative_array_ground_switch(ngs),
    .arrays_to_inputs(ati), .arrays_to_reference_ground(atr), .element_to_reference(elem),
    .analog_powered(pwr), .code_valid(cv), .code_ready(cr), .code_data(data),
    .start_overrun(ovf));
  function automatic logic [15:0] expect_code(input logic [15:0] t, input logic s, o, u);
    if (o) return s ? 16'h7FFF : 16'hFFFF;
    if (u) return s ? 16'h8000 : 16'h0000;
    return {t[15] ^ s, t[14:0]};
  endfunction
  task end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", what, e, s);
    end
  endtask
  task wait_busy(input logic v);
    int k;
    k = 0;
    while (busy !== v && k < 60) begin
      @(posedge mclk);
      k++;
    end
    chk("busy", 16'(v), 16'(busy));
    if (busy !== v) end_sim;
  endtask
  task conv(input logic take, input logic o, input logic u, input int gap);
    target <= 16'($urandom);
    sel <= 1'($urandom);
    ovr <= o;
    und <= u;
    repeat (gap) @(posedge mclk);
    go <= 1;
    @(posedge mclk) go <= 0;
    repeat (3) @(posedge mclk);
    chk("taken", 16'(take), 16'(busy));
    if (take) begin
      q.push_back(expect_code(target, sel, o, u));
      pd <= 1'($urandom);
      go <= 1;
      @(posedge mclk) go <= 0;
      wait_busy(0);
      pd <= 0;
    end
  endtask
  always @(posedge mclk) if (cv === 1 && cr === 1) begin
    chk("pending", 16'h0001, 16'(q.size() != 0));
    if (q.size() != 0) chk("code", q.pop_front(), data);
  end
  initial begin
    void'($urandom(94));
    repeat (6) @(posedge mclk);
    reset <= 0;
    @(posedge mclk);
    for (i = 0; i < 12; i++) begin
      conv(1, i == 0 || i == 3, i == 1 || i == 3, (i < 6) ? 6 : 6 + int'($urandom % 4));
    end
    conv(0, 0, 0, 5);
    repeat (20) @(posedge mclk);
    stall <= 1;
    for (i = 0; i < 8; i++) conv(1, 0, 0, 6);
    conv(0, 0, 0, 6);
    stall <= 0;
    for (i = 0; i < 200 && q.size() != 0; i++) @(posedge mclk);
    chk("left", 16'h0000, 16'(q.size()));
    end_sim;
  end
endmodule
`default_nettype wire
